// ==== include/cmp_edge_map.svh ====
/*
 offsets, field positions, reset values for the comparator edge control block.
 assumes inclusion by bare name; byte addresses are four times the printed indexes.
*/
`ifndef CMP_EDGE_MAP_SVH
`define CMP_EDGE_MAP_SVH
`define CTL1_IDX 8'h9a
`define CTL0_IDX 8'h9b
`define MODE0_IDX 8'h9d
`define MODE1_IDX 8'h9c
`define IRQ_STAT_IDX 8'ha0
`define IRQ_EN_IDX 8'ha1
`define IRQ_CLR_IDX 8'ha2
`define CTL_EN_BIT 7
`define CTL_OUT_BIT 6
`define CTL_RISE_BIT 5
`define CTL_FALL_BIT 4
`define MODE_RISE_MASK_BIT 5
`define MODE_FALL_MASK_BIT 4
`define CTL_RESET 8'h00
`define MODE_RESET 8'h02
`define HYS_OFF 2'h0
`define HYS_5MV 2'h1
`define HYS_10MV 2'h2
`define HYS_20MV 2'h3
`endif

// ==== include/cmp_edge_pkg.sv ====
/*
 types for the comparator edge control block.
 assumes nothing beyond a systemverilog compiler.
*/
package cmp_edge_pkg;
   typedef struct packed {
      logic enable;
      logic [1:0] pos_hys;
      logic [1:0] neg_hys;
      logic [1:0] resp_mode;
      logic rise_mask;
      logic fall_mask;
   } cmp_cfg_s;
   typedef struct packed {
      logic state;
      logic rise_flag;
      logic fall_flag;
   } cmp_stat_s;
   typedef enum logic [1:0] {
      RESP_FAST,
      RESP_MID1,
      RESP_MID2,
      RESP_SLOW
   } resp_mode_e;
endpackage

// ==== rtl/cmp_channel.sv ====
/*
 one comparator channel: synchroniser, edge flags, interrupt request.
 assumes raw_in is asynchronous; config from the register file on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cmp_channel (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic raw_in,
   input wire cmp_edge_pkg::cmp_cfg_s cfg,
   input wire logic clr_rise,
   input wire logic clr_fall,
   output cmp_edge_pkg::cmp_stat_s stat,
   output logic irq_req
);
   logic sync1_ff, sync2_ff, prev_ff, rise_ff, fall_ff;
   logic nxt_prev, nxt_rise, nxt_fall, rise_evt, fall_evt, gated;

   assign gated = sync2_ff & cfg.enable;
   assign rise_evt = gated & ~prev_ff;
   assign fall_evt = ~gated & prev_ff;

   always_comb begin
      nxt_prev = gated;
      nxt_rise = rise_ff;
      nxt_fall = fall_ff;
      if (clr_rise) begin
         nxt_rise = 1'b0;
      end
      if (clr_fall) begin
         nxt_fall = 1'b0;
      end
      // set beats a clear in the same cycle
      if (rise_evt) begin
         nxt_rise = 1'b1;
      end
      if (fall_evt) begin
         nxt_fall = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff <= 1'b0;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
         prev_ff <= nxt_prev;
         rise_ff <= nxt_rise;
         fall_ff <= nxt_fall;
      end
   end

   assign stat.state = prev_ff;
   assign stat.rise_flag = rise_ff;
   assign stat.fall_flag = fall_ff;
   assign irq_req = (rise_ff & cfg.rise_mask) | (fall_ff & cfg.fall_mask);

   a_rise_sets: assert property (@(posedge core_clk) disable iff (!arst_n)
      rise_evt |=> rise_ff) else $error("rise edge did not set flag");
   a_fall_sets: assert property (@(posedge core_clk) disable iff (!arst_n)
      fall_evt |=> fall_ff) else $error("fall edge did not set flag");
   a_rise_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
      rise_ff && !clr_rise |=> rise_ff) else $error("rise flag dropped");
   a_fall_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
      fall_ff && !clr_fall |=> fall_ff) else $error("fall flag dropped");
   a_sync_delay: assert property (@(posedge core_clk) disable iff (!arst_n)
      cfg.enable && $past(cfg.enable) ##0 $rose(sync2_ff) |=> stat.state)
      else $error("state lags sync");
endmodule
`default_nettype wire

// ==== rtl/cmp_edge_ctrl.sv ====
/*
 two-comparator control and status logic behind an axi4-lite slave.
 assumes raw analogue decisions arrive asynchronously; bus runs on core_clk.
*/
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
// Notes on behaviour
// - two identical comparator channels; only the first also feeds a reset output.
// - each channel gives a clocked latched output and an unclocked raw output.
// - the raw output is pure gating, so it works with the clock stopped.
// - a disabled comparator drives its outputs low and powers down its supply.
// - enable bit 1 turns the comparator on, 0 turns it off.
// - output state is readable at any time and drives interrupts and pins.
// - two independent 2-bit hysteresis fields in control bits 3:0.
// - a response mode field selects speed versus supply current.
// - interrupts are possible on both rising and falling transitions.
// - a falling edge sets the fall flag, a rising edge the rise flag.
// - edge flags stay set until software writes them to zero.
// - per-edge mask bits let each flag request an interrupt.
// - control register at 0x9b, reset zero, with documented bit layout.
// - hysteresis codes 00 off, 01 5mv, 10 10mv, 11 20mv.
// - mode register at 0x9d: masks in bits 5:4, mode in 1:0 resetting to 10.
// - mode 00 fastest and hungriest, 11 slowest and leanest.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_edge_map.svh"
module cmp_edge_ctrl (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cmp_zero_decision,
   input wire logic cmp_one_decision,
   output logic cmp_zero_latched_out,
   output logic cmp_one_latched_out,
   output logic cmp_zero_raw_out,
   output logic cmp_one_raw_out,
   output logic cmp_zero_reset_src,
   output logic [1:0] cmp_power_on,
   output logic [3:0] cmp_zero_hys,
   output logic [3:0] cmp_one_hys,
   output logic [1:0] cmp_zero_resp,
   output logic [1:0] cmp_one_resp,
   output logic irq
);
   cmp_edge_pkg::cmp_cfg_s cfg [2];
   cmp_edge_pkg::cmp_stat_s stat [2];
   logic [1:0] irq_req;
   logic [1:0] clr_rise, clr_fall;
   logic [7:0] ctl_ff [2];
   logic [7:0] mode_ff [2];
   logic [7:0] nxt_ctl [2];
   logic [7:0] nxt_mode [2];
   logic [1:0] irq_stat_ff, irq_en_ff, nxt_irq_stat, nxt_irq_en, prev_req_ff;
   logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff, awready_ff, wready_ff, arready_ff;
   logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
   logic [7:0] awidx_ff, nxt_awidx;
   logic [7:0] wdat_ff, nxt_wdat;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic wr_fire, wr_hit;
   logic [7:0] ridx;
   logic irq_ff, nxt_irq;
   logic [1:0] latched_ff;
   logic [1:0] raw_in;

   assign raw_in = {cmp_one_decision, cmp_zero_decision};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : ch
         assign cfg[g].enable = ctl_ff[g][`CTL_EN_BIT];
         assign cfg[g].pos_hys = ctl_ff[g][3:2];
         assign cfg[g].neg_hys = ctl_ff[g][1:0];
         assign cfg[g].resp_mode = mode_ff[g][1:0];
         assign cfg[g].rise_mask = mode_ff[g][`MODE_RISE_MASK_BIT];
         assign cfg[g].fall_mask = mode_ff[g][`MODE_FALL_MASK_BIT];
         cmp_channel u_ch (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .raw_in(raw_in[g]),
            .cfg(cfg[g]),
            .clr_rise(clr_rise[g]),
            .clr_fall(clr_fall[g]),
            .stat(stat[g]),
            .irq_req(irq_req[g])
         );
      end
   endgenerate

   // raw path is combinational by nature: no clock, still valid in stop mode
   assign cmp_zero_raw_out = cmp_zero_decision & ctl_ff[0][`CTL_EN_BIT];
   assign cmp_one_raw_out = cmp_one_decision & ctl_ff[1][`CTL_EN_BIT];
   assign cmp_zero_latched_out = latched_ff[0];
   assign cmp_one_latched_out = latched_ff[1];
   assign cmp_zero_reset_src = latched_ff[0];
   assign cmp_power_on = {ctl_ff[1][`CTL_EN_BIT], ctl_ff[0][`CTL_EN_BIT]};
   assign cmp_zero_hys = ctl_ff[0][3:0];
   assign cmp_one_hys = ctl_ff[1][3:0];
   assign cmp_zero_resp = mode_ff[0][1:0];
   assign cmp_one_resp = mode_ff[1][1:0];

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign irq = irq_ff;

   assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
   assign ridx = s_axi_araddr[9:2];

   always_comb begin
      wr_hit = 1'b0;
      case (awidx_ff)
         `CTL0_IDX, `CTL1_IDX, `MODE0_IDX, `MODE1_IDX, `IRQ_STAT_IDX, `IRQ_EN_IDX, `IRQ_CLR_IDX: begin
            wr_hit = 1'b1;
         end
         default: begin
            wr_hit = 1'b0;
         end
      endcase
   end

   // write channel and register updates
   always_comb begin
      nxt_aw_got = aw_got_ff;
      nxt_w_got = w_got_ff;
      nxt_awidx = awidx_ff;
      nxt_wdat = wdat_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_ctl = ctl_ff;
      nxt_mode = mode_ff;
      nxt_irq_en = irq_en_ff;
      clr_rise = 2'b00;
      clr_fall = 2'b00;
      nxt_irq_stat = irq_stat_ff;
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_got = 1'b1;
         nxt_awidx = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_got = 1'b1;
         // only the low lane carries register data
         nxt_wdat = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wr_fire) begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = wr_hit ? 2'h0 : 2'h2;
         case (awidx_ff)
            `CTL0_IDX, `CTL1_IDX: begin
               for (int i = 0; i < 2; i++) begin
                  if (awidx_ff == (i == 0 ? `CTL0_IDX : `CTL1_IDX)) begin
                     // output state is read-only; flags only clear on a zero write
                     nxt_ctl[i] = {wdat_ff[7], 3'h0, wdat_ff[3:0]};
                     clr_rise[i] = ~wdat_ff[`CTL_RISE_BIT];
                     clr_fall[i] = ~wdat_ff[`CTL_FALL_BIT];
                  end
               end
            end
            `MODE0_IDX: begin
               nxt_mode[0] = {2'h0, wdat_ff[5:4], 2'h0, wdat_ff[1:0]};
            end
            `MODE1_IDX: begin
               nxt_mode[1] = {2'h0, wdat_ff[5:4], 2'h0, wdat_ff[1:0]};
            end
            `IRQ_EN_IDX: begin
               nxt_irq_en = wdat_ff[1:0];
            end
            `IRQ_CLR_IDX: begin
               nxt_irq_stat = irq_stat_ff & ~wdat_ff[1:0];
            end
            default: begin
               nxt_bresp = wr_hit ? 2'h0 : 2'h2;
            end
         endcase
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      // a new request edge wins over a clear
      nxt_irq_stat = nxt_irq_stat | (irq_req & ~prev_req_ff);
      nxt_irq = |(nxt_irq_stat & nxt_irq_en);
   end

   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (s_axi_arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = 2'h0;
         case (ridx)
            `CTL0_IDX: nxt_rdata = {24'h0, ctl_ff[0][7], stat[0].state, stat[0].rise_flag,
                                    stat[0].fall_flag, ctl_ff[0][3:0]};
            `CTL1_IDX: nxt_rdata = {24'h0, ctl_ff[1][7], stat[1].state, stat[1].rise_flag,
                                    stat[1].fall_flag, ctl_ff[1][3:0]};
            `MODE0_IDX: nxt_rdata = {24'h0, mode_ff[0]};
            `MODE1_IDX: nxt_rdata = {24'h0, mode_ff[1]};
            `IRQ_STAT_IDX: nxt_rdata = {30'h0, irq_stat_ff};
            `IRQ_EN_IDX: nxt_rdata = {30'h0, irq_en_ff};
            `IRQ_CLR_IDX: nxt_rdata = 32'h0;
            default: begin
               nxt_rdata = 32'h0;
               nxt_rresp = 2'h2;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_ff[0] <= `CTL_RESET;
         ctl_ff[1] <= `CTL_RESET;
         mode_ff[0] <= `MODE_RESET;
         mode_ff[1] <= `MODE_RESET;
         irq_en_ff <= 2'h0;
         irq_stat_ff <= 2'h0;
         prev_req_ff <= 2'h0;
         irq_ff <= 1'b0;
         latched_ff <= 2'h0;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awidx_ff <= 8'h00;
         wdat_ff <= 8'h00;
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'h0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= 2'h0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         arready_ff <= 1'b0;
      end else begin
         ctl_ff <= nxt_ctl;
         mode_ff <= nxt_mode;
         irq_en_ff <= nxt_irq_en;
         irq_stat_ff <= nxt_irq_stat;
         prev_req_ff <= irq_req;
         irq_ff <= nxt_irq;
         latched_ff <= {stat[1].state, stat[0].state};
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         awidx_ff <= nxt_awidx;
         wdat_ff <= nxt_wdat;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
         wready_ff <= ~nxt_w_got & ~nxt_bvalid;
         arready_ff <= ~nxt_rvalid;
      end
   end

   a_mode_reset: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(arst_n) |-> mode_ff[0][1:0] == 2'h2) else $error("mode reset wrong");
   a_disable_low: assert property (@(posedge core_clk) disable iff (!arst_n)
      !ctl_ff[0][7] |-> ##2 !cmp_zero_latched_out || ctl_ff[0][7]) else $error("disabled out high");
   a_latch_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
      1'b1 |=> cmp_zero_latched_out == $past(stat[0].state)) else $error("latched lag wrong");
   a_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n)
      |(irq_stat_ff & irq_en_ff) |-> irq) else $error("irq not raised");
   a_ctl_write: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_fire && awidx_ff == `CTL0_IDX |=> ctl_ff[0][7] == $past(wdat_ff[7])) else $error("enable not written");
   a_hys_write: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_fire && awidx_ff == `CTL1_IDX |=> cmp_one_hys == $past(wdat_ff[3:0])) else $error("hysteresis not written");
   // status latches the request edge, so a held request cannot refire after a clear
   a_stat_edge: assert property (@(posedge core_clk) disable iff (!arst_n)
      irq_req[0] && !prev_req_ff[0] |=> irq_stat_ff[0]) else $error("status missed request edge");
   a_raw_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
      !ctl_ff[1][`CTL_EN_BIT] |-> !cmp_one_raw_out) else $error("disabled raw out high");
   a_pwr_write: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_fire && awidx_ff == `CTL1_IDX |=> cmp_power_on[1] == $past(wdat_ff[7])) else $error("power not written");
   a_mode_unused: assert property (@(posedge core_clk) disable iff (!arst_n)
      mode_ff[1][7:6] == 2'h0 && mode_ff[1][3:2] == 2'h0) else $error("unused mode bits set");
endmodule
`default_nettype wire

// ==== verification/cmp_front_model.sv ====
/*
 behavioural analogue front end standing in for both comparators.
 assumes power_on and the response modes come from the control block.
*/
`timescale 1ns/1ps
`default_nettype none
module cmp_front_model (
   input wire logic [1:0] power_on,
   input wire logic [1:0] resp0,
   input wire logic [1:0] resp1,
   input wire logic [1:0] level,
   output logic [1:0] dec
);
   initial dec = 2'h0;
   for (genvar i = 0; i < 2; i++) begin : g_ch
      always begin
         if (power_on[i] === 1'b1) begin
            // slowest mode answers late, as the real part does
            dec[i] = #(((i ? resp1 : resp0) == cmp_edge_pkg::RESP_SLOW) ? 40 : 3) level[i];
            if (dec[i] === level[i]) @(level[i] or power_on[i]);
         end else begin
            // unpowered: no valid decision, so it wanders
            #7 dec[i] = ~dec[i];
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/cmp_edge_control_tb_top.sv ====
/*
 self-checking bench for the comparator edge control block over axi4-lite.
 assumes the front end model above and byte address four times the index.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmp_edge_map.svh"
module comparator_edge_control_tb_top;
   logic core_clk = 1'b0;
   logic clk_run = 1'b1;
   logic arst_n = 1'b0;
   logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic cmp_zero_latched_out, cmp_one_latched_out, cmp_zero_raw_out, cmp_one_raw_out;
   logic cmp_zero_reset_src, irq;
   logic [1:0] cmp_power_on, cmp_zero_resp, cmp_one_resp, dec;
   logic [3:0] cmp_zero_hys, cmp_one_hys;
   logic [1:0] level = 2'h0;
   logic [1:0] bresp_seen;
   logic [7:0] ctl [2] = '{`CTL0_IDX, `CTL1_IDX};
   logic [7:0] md [2] = '{`MODE0_IDX, `MODE1_IDX};
   int fails = 0;
   int compares = 0;

   // gated so the raw path can be seen with the clock stopped
   always #2.5 if (clk_run) core_clk = ~core_clk;

   cmp_edge_ctrl dut (
      .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cmp_zero_decision(dec[0]), .cmp_one_decision(dec[1]), .cmp_zero_latched_out,
      .cmp_one_latched_out, .cmp_zero_raw_out, .cmp_one_raw_out, .cmp_zero_reset_src,
      .cmp_power_on, .cmp_zero_hys, .cmp_one_hys, .cmp_zero_resp, .cmp_one_resp, .irq
   );

   cmp_front_model front (
      .power_on(cmp_power_on), .resp0(cmp_zero_resp), .resp1(cmp_one_resp), .level(level), .dec(dec)
   );

   task automatic test_done();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic bound(input int n);
      if (n >= 100) begin
         fails++;
         $display("Error bus answer expected within 100 cycles seen none");
         test_done();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      int n;
      logic a;
      logic w;
      @(posedge core_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      a = 1'b0;
      w = 1'b0;
      while (!(a && w) && n < 100) begin
         @(posedge core_clk);
         n++;
         a = a | (s_axi_awvalid & s_axi_awready);
         w = w | (s_axi_wvalid & s_axi_wready);
         s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
      end
      while (s_axi_bvalid !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      bresp_seen = s_axi_bresp;
      s_axi_bready <= 1'b0;
      bound(n);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] rexp);
      int n;
      @(posedge core_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      bound(n);
      chk("rdata", {24'h000000, exp}, s_axi_rdata);
      chk("rresp", rexp, s_axi_rresp);
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      tick(2);
      for (int c = 0; c < 2; c++) begin
         rd(ctl[c], `CTL_RESET, 2'h0);
         rd(md[c], `MODE_RESET, 2'h0);
      end
      chk("resp", 4'ha, {cmp_one_resp, cmp_zero_resp});
      rd(8'h10, 8'h00, 2'h2);
      wr(8'h10, 8'hff);
      chk("bresp", 2'h2, bresp_seen);
      // opposite values on the two channels catch crossed wiring
      for (int i = 0; i < 16; i++) begin
         wr(ctl[0], 8'(i));
         wr(ctl[1], 8'(15 - i));
         tick(2);
         chk("hys", {4'(15 - i), 4'(i)}, {cmp_one_hys, cmp_zero_hys});
      end
      for (int m = 0; m < 4; m++) begin
         wr(md[0], 8'hcc | 8'(m));
         wr(md[1], 8'hcc | 8'(3 - m));
         tick(2);
         chk("resp", {2'(3 - m), 2'(m)}, {cmp_one_resp, cmp_zero_resp});
         rd(md[0], 8'(m), 2'h0);
         rd(md[1], 8'(3 - m), 2'h0);
      end
      // channel 0 fast with fall mask, channel 1 slow with rise mask
      for (int c = 0; c < 2; c++) begin
         wr(ctl[c], 8'h80);
         tick(20);
         wr(ctl[c], 8'h80);
         wr(md[c], c ? 8'h23 : 8'h10);
         wr(`IRQ_CLR_IDX, 8'h03);
         wr(`IRQ_EN_IDX, 8'h03);
         rd(ctl[c], 8'h80, 2'h0);
         chk("pwr", 1, cmp_power_on[c]);
         @(posedge core_clk);
         level[c] <= 1'b1;
         tick(20);
         rd(ctl[c], 8'he0, 2'h0);
         chk("latched", 2'h1 << c, {cmp_one_latched_out, cmp_zero_latched_out});
         chk("raw", 2'h1 << c, {cmp_one_raw_out, cmp_zero_raw_out});
         chk("rst src", c == 0, cmp_zero_reset_src);
         chk("irq rise", c, irq);
         @(posedge core_clk);
         level[c] <= 1'b0;
         tick(20);
         rd(ctl[c], 8'hb0, 2'h0);
         chk("irq fall", 1, irq);
         rd(`IRQ_STAT_IDX, 8'h01 << c, 2'h0);
         wr(`IRQ_EN_IDX, 8'h00);
         tick(2);
         chk("irq off", 0, irq);
         wr(ctl[c], 8'h80);
         rd(ctl[c], 8'h80, 2'h0);
         wr(`IRQ_CLR_IDX, 8'h03);
         wr(`IRQ_EN_IDX, 8'h03);
         tick(2);
         chk("irq clr", 0, irq);
      end
      // raw path must follow with no clock edges at all
      @(posedge core_clk);
      clk_run <= 1'b0;
      #20 level[0] <= 1'b1;
      #20 chk("raw stop", 1, cmp_zero_raw_out);
      level[0] <= 1'b0;
      #20 chk("raw stop", 0, cmp_zero_raw_out);
      clk_run <= 1'b1;
      @(posedge core_clk);
      level <= 2'h3;
      tick(20);
      wr(`CTL0_IDX, 8'h00);
      wr(`CTL1_IDX, 8'h00);
      tick(20);
      chk("pins off", 4'h0, {cmp_zero_raw_out, cmp_one_raw_out, cmp_zero_latched_out, cmp_one_latched_out});
      chk("pwr off", 0, cmp_power_on);
      test_done();
   end
endmodule
`default_nettype wire
